/* rtl/wdtd_top.sv */
// Watchdog time base: oscillator-driven prescaler and postscaler
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Counter chain advances only on rising edges of the low-power RC oscillator.
// - Enabling the watchdog turns on its oscillator automatically.
// - Prescaler divides by 32 or 128, chosen by prescale-select bit.
// - At 1:1 postscale, period is about 1 ms or 4 ms.
// - Postscaler divides further, sixteen settings from 1:1 to 1:32768.
module wdtd_top #(
  // Prescaler widths in the short and long modes
  parameter int unsigned PRE_W_SHORT = wdtd_pkg::PRE_BITS_SHORT,
  parameter int unsigned PRE_W_LONG  = wdtd_pkg::PRE_BITS_LONG,
  // Postscaler counter width, enough for the largest ratio
  parameter int unsigned POST_CNT_W  = wdtd_pkg::POST_CNT_W
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Configuration word and software clear
  input  wire wdtd_pkg::wdtd_cfg_t watchdog_config_word,
  input  wire logic                wdt_clear,
  // Oscillator pin and its enable
  input  wire logic                low_power_rc_oscillator,
  output logic                     rc_osc_enable,
  // Status
  output logic                     wdt_timeout,
  output logic                     wdt_expired
);

  // Chain states: off, counting, or counting on past an expiry
  typedef enum logic [1:0] {
    ST_OFF,
    ST_COUNT,
    ST_EXPIRED
  } wdtd_state_t;

  // Counter end points and steps at the chosen widths
  localparam logic [PRE_W_LONG-1:0] PRE_ZERO  =
    PRE_W_LONG'(wdtd_pkg::PRE_RST);
  localparam logic [PRE_W_LONG-1:0] PRE_ONE   =
    PRE_W_LONG'(1);
  localparam logic [POST_CNT_W-1:0] POST_ZERO =
    POST_CNT_W'(wdtd_pkg::POST_RST);
  localparam logic [POST_CNT_W-1:0] POST_ONE  =
    POST_CNT_W'(1);

  // All-ones value of a given width: a prescaler terminal count
  function automatic logic [PRE_W_LONG-1:0] pre_ones(
    input int unsigned bits
  );
    pre_ones = PRE_W_LONG'((64'h1 << bits) - 64'h1);
  endfunction

  // Last postscaler count for a select value: 2**sel - 1
  function automatic logic [POST_CNT_W-1:0] post_last(
    input logic [wdtd_pkg::POST_SEL_W-1:0] sel
  );
    post_last = POST_CNT_W'((64'h1 << sel) - 64'h1);
  endfunction

  // Oscillator synchroniser and level tracker
  logic [2:0]                  osc_sync_r;
  logic                        osc_lvl_r;
  logic                        osc_lvl_nxt;

  // Counter chain
  logic [PRE_W_LONG-1:0]       pre_cnt_r;
  logic [PRE_W_LONG-1:0]       pre_cnt_nxt;
  logic [POST_CNT_W-1:0]       post_cnt_r;
  logic [POST_CNT_W-1:0]       post_cnt_nxt;

  // Status bundle and chain state
  wdtd_pkg::wdtd_stat_t        stat_r;
  wdtd_pkg::wdtd_stat_t        stat_nxt;
  wdtd_state_t                 state_r;
  wdtd_state_t                 state_nxt;

  // Oscillator edge: new level counts only once stages two and three agree
  wire osc_agree = osc_sync_r[1] == osc_sync_r[2];
  wire osc_rise  = osc_agree & osc_sync_r[2] & ~osc_lvl_r;

  // Runs from the cycle after enable, when the oscillator is already on
  wire run       = watchdog_config_word.enable & (state_r != ST_OFF);
  wire tick      = run & osc_rise;

  // Prescaler terminal count follows the select bit
  wire [PRE_W_LONG-1:0] pre_last_short = pre_ones(PRE_W_SHORT);
  wire [PRE_W_LONG-1:0] pre_last_long  = pre_ones(PRE_W_LONG);
  wire [PRE_W_LONG-1:0] pre_last       =
    watchdog_config_word.prescale_select ?
    pre_last_long :
    pre_last_short;
  wire pre_wrap = tick & (pre_cnt_r == pre_last);

  // Postscaler terminal count follows the select field
  wire [POST_CNT_W-1:0] post_end_val =
    post_last(watchdog_config_word.postscale_select);
  wire post_end = post_cnt_r == post_end_val;
  wire expire   = pre_wrap & post_end;

  // A clear or a disable holds the whole chain at zero
  wire restart  = wdt_clear | ~watchdog_config_word.enable;

  // A clear in the same cycle suppresses the pulse: the chain restarts
  wire timeout_set  = expire & ~restart;

  // Sticky flag: a clear wins over a fresh expiry in the same cycle
  wire expired_keep = stat_r.expired & ~wdt_clear;

  // Level tracker only moves once the last two stages agree
  assign osc_lvl_nxt = osc_agree ? osc_sync_r[2] : osc_lvl_r;

  // Prescaler next value
  assign pre_cnt_nxt = restart  ? PRE_ZERO :
                       pre_wrap ? PRE_ZERO :
                       tick     ? pre_cnt_r + PRE_ONE :
                       pre_cnt_r;

  // Postscaler next value
  assign post_cnt_nxt = restart  ? POST_ZERO :
                        expire   ? POST_ZERO :
                        pre_wrap ? post_cnt_r + POST_ONE :
                        post_cnt_r;

  // Status next value
  assign stat_nxt = '{
    timeout_pulse: timeout_set,
    expired:       timeout_set | expired_keep,
    osc_enable:    watchdog_config_word.enable
  };

  // Chain state: disable always wins and drops back to off
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        state_nxt = ST_COUNT;
      end
      ST_COUNT: begin
        if (timeout_set) begin
          state_nxt = ST_EXPIRED;
        end
      end
      ST_EXPIRED: begin
        if (wdt_clear) begin
          state_nxt = ST_COUNT;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!watchdog_config_word.enable) begin
      state_nxt = ST_OFF;
    end
  end

  // Pin synchroniser; only the second stage reads the first
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      osc_sync_r <= 3'h0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], low_power_rc_oscillator};
    end
  end

  // Settled oscillator level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      osc_lvl_r <= 1'b0;
    end else begin
      osc_lvl_r <= osc_lvl_nxt;
    end
  end

  // Prescaler
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pre_cnt_r <= PRE_ZERO;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // Postscaler
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      post_cnt_r <= POST_ZERO;
    end else begin
      post_cnt_r <= post_cnt_nxt;
    end
  end

  // Status flags
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Chain state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flops
  assign rc_osc_enable = stat_r.osc_enable;
  assign wdt_timeout   = stat_r.timeout_pulse;
  assign wdt_expired   = stat_r.expired;

endmodule

`default_nettype wire

/* rtl/wdtd_pkg.sv */
// Package with constants and types for the watchdog time base
package wdtd_pkg;

  // Oscillator and time figures
  localparam int unsigned RC_OSC_FREQ_HZ   = 31000;
  localparam int unsigned SYS_FREQ_HZ      = 50000000;
  localparam int unsigned TIMEOUT_SHORT_MS = 1;
  localparam int unsigned TIMEOUT_LONG_MS  = 4;

  // Prescaler widths: 5-bit and 7-bit modes
  localparam int unsigned PRE_BITS_SHORT = 5;
  localparam int unsigned PRE_BITS_LONG  = 7;
  localparam logic [6:0]  PRE_LAST_SHORT = 7'h1f;
  localparam logic [6:0]  PRE_LAST_LONG  = 7'h7f;

  // Postscaler: 4-bit select, ratios 1:1 to 1:32768
  localparam int unsigned POST_SEL_W = 4;
  localparam int unsigned POST_CNT_W = 15;

  // Reset values
  localparam logic [6:0]  PRE_RST  = 7'h00;
  localparam logic [14:0] POST_RST = 15'h0000;

  // Configuration word carried as one bundle
  typedef struct packed {
    logic                  enable;
    logic                  prescale_select;
    logic [POST_SEL_W-1:0] postscale_select;
  } wdtd_cfg_t;

  // Time-base status carried as one bundle
  typedef struct packed {
    logic                  timeout_pulse;
    logic                  expired;
    logic                  osc_enable;
  } wdtd_stat_t;

endpackage

/* test/wdtd_checker.sv */
// Assertions for the watchdog time base
`timescale 1ns/100ps
`default_nettype none
module wdtd_checker (
  // Inputs
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                wdt_clear,
  input wire logic                low_power_rc_oscillator,
  input wire wdtd_pkg::wdtd_cfg_t watchdog_config_word,
  // Outputs
  input wire logic                rc_osc_enable,
  input wire logic                wdt_timeout,
  input wire logic                wdt_expired
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic en = watchdog_config_word.enable;
  osc_on_a: assert property (en |=> rc_osc_enable) else $error("osc off");
  osc_off_a: assert property (!en |=> !rc_osc_enable) else $error("osc on");
  // Sync delay is 3-4 cycles, so 8 quiet cycles rule out a fresh tick
  osc_only_a: assert property ($stable(low_power_rc_oscillator)[*8]
    |=> !wdt_timeout) else $error("tick without osc");
  pulse_one_a: assert property (wdt_timeout |=> !wdt_timeout) else $error("long");
  exp_set_a: assert property (wdt_timeout |-> wdt_expired) else $error("exp");
  clr_wins_a: assert property (wdt_clear |=> !wdt_timeout && !wdt_expired)
    else $error("clear lost");
  off_quiet_a: assert property (!en |=> !wdt_timeout) else $error("off");
  cover property (wdt_timeout);
  cover property (wdt_clear && wdt_expired);
  cover property (!en ##1 en);
endmodule
bind wdtd_top wdtd_checker chk (.sys_clk, .rstn, .wdt_clear,
  .low_power_rc_oscillator, .watchdog_config_word, .rc_osc_enable,
  .wdt_timeout, .wdt_expired);
`default_nettype wire

/* test/wdtd_tb_top.sv */
// Self-checking bench for the watchdog time base
`timescale 1ns/100ps
`default_nettype none
module wdtd_tb_top;
  logic sys_clk = 0, rstn = 0, wdt_clear = 0, osc = 0;
  wdtd_pkg::wdtd_cfg_t cfg = '0;
  logic rc_osc_enable, wdt_timeout, wdt_expired;
  int mismatches = 0, checks_done = 0, seed = 24596, cyc = 0;
  wdtd_top uut (.sys_clk, .rstn, .watchdog_config_word(cfg), .wdt_clear,
    .low_power_rc_oscillator(osc), .rc_osc_enable, .wdt_timeout, .wdt_expired);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc == 60000) begin
    mismatches++;
    stop_test;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Oscillator stays at least 16 cycles per period, well under sys_clk/8
  task automatic run(input logic pre, input logic [3:0] post, input bit mid);
    int rises, k, exp;
    exp = (pre ? 128 : 32) << post;
    tick(8);
    cfg = '{1'b1, pre, post};
    wdt_clear = 1;
    tick(1);
    wdt_clear = 0;
    chk(wdt_expired, 0);
    chk(rc_osc_enable, 1);
    for (rises = 1; rises <= exp + 1; rises++) begin
      osc = 1;
      for (k = 0; k < 8 && wdt_timeout !== 1; k++) tick(1);
      osc = 0;
      if (wdt_timeout === 1) break;
      tick(8 + ($random(seed) & 7));
      if (mid && rises == exp / 2) begin
        wdt_clear = 1;
        tick(1);
        wdt_clear = 0;
        rises = 0;
        mid = 0;
      end
    end
    chk(rises, exp);
    chk(wdt_expired, 1);
  endtask
  initial begin
    tick(20);
    rstn = 1;
    chk({wdt_timeout, wdt_expired, rc_osc_enable}, 0);
    for (int p = 0; p < 2; p++)
      for (int q = 0; q < 3; q++) run(p[0], q[3:0], q == 1);
    cfg = '{1'b0, 1'b0, 4'h0};
    tick(1);
    chk(rc_osc_enable, 0);
    repeat (80) begin
      osc = ~osc;
      tick(8);
      chk(wdt_timeout, 0);
    end
    stop_test;
  end
endmodule
`default_nettype wire
